// ---- rtl/dma_pkg.sv ----
// Purpose: shared constants and types of the four-channel cycle-steal dma
// Assumes: one clock, plain register port, 32-bit memory bus
// Notes:   register index is addr[7:4] = field, addr[3:2] = channel
package dma_pkg;
  localparam int unsigned NUM_CH    = 4;          // channels
  localparam int unsigned AW        = 32;         // address width
  localparam int unsigned DW        = 32;         // data width
  localparam int unsigned CNT_W     = 32;         // transfer count width
  localparam int unsigned SRC_W     = 32;         // request source lines
  localparam int unsigned RA_W      = 8;          // register address width

  // register fields (addr[7:4])
  localparam logic [3:0] F_MODE     = 4'h0;       // channel mode register
  localparam logic [3:0] F_COUNT    = 4'h1;       // transfer count
  localparam logic [3:0] F_CRELOAD  = 4'h2;       // count reload
  localparam logic [3:0] F_SRC      = 4'h3;       // source pointer
  localparam logic [3:0] F_SRELOAD  = 4'h4;       // source reload
  localparam logic [3:0] F_DST      = 4'h5;       // dest pointer
  localparam logic [3:0] F_DRELOAD  = 4'h6;       // dest reload
  localparam logic [3:0] F_SEL      = 4'h7;       // source select register
  localparam logic [3:0] F_SEL2     = 4'h8;       // extended select register
  localparam logic [3:0] F_STATUS   = 4'h9;       // status (read only)

  // mode, sel2 and status register fields
  localparam int unsigned MD_LO     = 0;          // transfer mode bits [1:0]
  localparam int unsigned SZ_LO     = 2;          // unit size bits [3:2]
  localparam int unsigned SINC_BIT  = 4;          // source increments
  localparam int unsigned DINC_BIT  = 5;          // dest increments
  localparam int unsigned SWREQ_BIT = 5;          // sw request in sel2
  localparam int unsigned DONE_BIT  = 0;          // status: run completed
  localparam int unsigned BUSY_BIT  = 1;          // status: request pending
  localparam int unsigned TC_BIT    = 2;          // status: complete irq

  localparam logic [1:0] MODE_OFF    = 2'b00;     // disabled
  localparam logic [1:0] MODE_SINGLE = 2'b01;     // single transfer
  localparam logic [1:0] MODE_REPEAT = 2'b11;     // repeat transfer

  localparam logic [1:0] SZ_8       = 2'b00;      // byte unit
  localparam logic [1:0] SZ_16      = 2'b01;      // halfword unit
  localparam logic [1:0] SZ_32      = 2'b10;      // word unit

  localparam logic [4:0] SEL_EXT    = 5'h00;      // redirect to sel2
  localparam logic [4:0] SEL_MASK   = 5'h1F;      // select field mask

  // 64-mbyte space: low 32 mbyte and high 32 mbyte window
  localparam logic [AW-1:0] LOW_LIMIT  = 32'h01FF_FFFF; // low top
  localparam logic [AW-1:0] HIGH_BASE  = 32'hFE00_0000; // high base
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001; // last unit
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000; // run done
  localparam logic [DW-1:0] ZERO_W     = 32'h0000_0000; // zero word

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,                           // waiting for request
    ST_READ  = 4'b0010,                           // source read cycle
    ST_WRITE = 4'b0100,                           // dest write cycle
    ST_DONE  = 4'b1000                            // update pointers
  } xfer_state_t;
endpackage

// ---- rtl/dma_req_if.sv ----
// Purpose: carries the request/grant pairing between arbiter and engine
// Assumes: single clock domain
// Notes:   arbiter owns req lines, engine owns the ack pulse
`timescale 1ns/100ps
interface dma_req_if;
  import dma_pkg::*;
  logic [NUM_CH-1:0] pend;                        // pending per channel
  logic [NUM_CH-1:0] ack;                         // taken by engine
  modport arb (output pend, input ack);           // request side
  modport eng (input pend, output ack);           // engine side
endinterface

// ---- rtl/dma_req_latch.sv ----
// Purpose: per-channel trigger selection and pending request latch
// Assumes: trigger inputs synchronous to core_clk, one pulse per event
// Notes:   requests ignore any interrupt mask and leave sources alone
`timescale 1ns/100ps
module dma_req_latch
  import dma_pkg::*;
(
  input  wire logic              core_clk,        // system clock
  input  wire logic              rst_n,           // async reset, low
  input  wire logic [SRC_W-1:0]  trig,            // hardware triggers
  input  wire logic [NUM_CH*5-1:0] sel,           // select fields
  input  wire logic [NUM_CH*5-1:0] sel2,          // extended selects
  input  wire logic [NUM_CH-1:0] sw_req,          // software strobes
  input  wire logic [NUM_CH-1:0] enable,          // channel armed
  dma_req_if.arb                 rq               // to engine
);
  // selection decoding, used by every channel
  function automatic logic [4:0] pick(input logic [4:0] s,
                                      input logic [4:0] s2);
    pick = (s == SEL_EXT) ? s2 : s;
  endfunction

  logic              pend_q [NUM_CH];             // latched requests

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign rq.pend[c] = pend_q[c];                // one element per process
    wire logic [4:0] code = pick(sel[c*5 +: 5], sel2[c*5 +: 5]); // RL18
    // code 0 after redirect means no hardware source
    wire logic hw = (code != SEL_EXT) && trig[code];    // RL14 RL16
    wire logic set = enable[c] && (hw || sw_req[c]);     // RL17
    // new request wins over the ack in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pend_q[c] <= 1'b0;
      end else if (set) begin
        pend_q[c] <= 1'b1;
      end else if (rq.ack[c] || !enable[c]) begin
        pend_q[c] <= 1'b0;                        // RL13
      end
    end
  end
endmodule

// ---- rtl/dma_core.sv ----
// Purpose: four-channel cycle-steal dma engine with register port
// Assumes: memory bus answers reads in the same cycle that mem_rd is high
// Notes:   one unit per request; bus_req takes priority over the cpu
//
// Summary of operation
// RL1: four channels, one 8/16/32-bit unit per request
// RL2: dma wins the shared bus over cpu
// RL3: channel 0 highest, channel 3 lowest
// RL4: addresses in low or high 32-mbyte region
// RL5: 32-bit counter covers maximum run
// RL6: pointers increment or stay fixed
// RL7: single mode stops at count zero
// RL8: repeat mode reloads count and continues
// RL9: repeat reloads count, source, dest at one-to-zero
// RL10: complete irq exactly at one-to-zero
// RL11: single starts if count nonzero, mode 01
// RL12: repeat starts if count nonzero, mode 11
// RL13: mode 00 disables and stops channel
// RL14: triggers from pins, timers, serial, converter, sw
// RL15: reload registers unused in single mode
// RL16: requests ignore masks, leave pending flags alone
// RL17: software request bit write is a request
// RL18: five-bit select with extended redirect code
// RL19: each unit decrements count, advances pointers
`timescale 1ns/100ps
module dma_core
  import dma_pkg::*;
(
  input  wire logic              core_clk,        // 10 mhz system clock
  input  wire logic              rst_n,           // async reset, low
  input  wire logic [RA_W-1:0]   reg_addr,        // register byte address
  input  wire logic [DW-1:0]     reg_wdata,       // register write data
  input  wire logic              reg_wr,          // write strobe
  input  wire logic              reg_rd,          // read strobe
  output logic      [DW-1:0]     reg_rdata,       // read data, next cycle
  input  wire logic [SRC_W-1:0]  trig,            // hardware triggers
  output logic                   bus_req,         // own the shared bus
  input  wire logic              cpu_bus_req,     // cpu wants the bus
  output logic                   cpu_bus_gnt,     // cpu may use the bus
  output logic      [AW-1:0]     mem_addr,        // memory address
  output logic                   mem_rd,          // memory read strobe
  output logic                   mem_wr,          // memory write strobe
  output logic      [1:0]        mem_size,        // unit size code
  output logic      [DW-1:0]     mem_wdata,       // memory write data
  input  wire logic [DW-1:0]     mem_rdata,       // memory read data
  output logic      [NUM_CH-1:0] tc_irq           // complete pulse
);
  // per-channel register arrays
  logic [5:0]       mode_q   [NUM_CH];            // mode register
  logic [CNT_W-1:0] cnt_q    [NUM_CH];            // transfer count
  logic [CNT_W-1:0] crl_q    [NUM_CH];            // count reload
  logic [AW-1:0]    src_q    [NUM_CH];            // source pointer
  logic [AW-1:0]    srl_q    [NUM_CH];            // source reload
  logic [AW-1:0]    dst_q    [NUM_CH];            // dest pointer
  logic [AW-1:0]    drl_q    [NUM_CH];            // dest reload
  logic [4:0]       sel_q    [NUM_CH];            // source select
  logic [4:0]       sel2_q   [NUM_CH];            // extended select
  logic              done_q   [NUM_CH];           // run finished flags

  // engine state
  xfer_state_t       st_q;                        // one-hot state
  logic [1:0]        ch_q;                        // channel in service
  logic [DW-1:0]     data_q;                      // unit in flight

  dma_req_if rq ();                               // request pairing

  // address decode shared by reads and writes
  wire logic [3:0] fld = reg_addr[7:4];           // register field
  wire logic [1:0] rch = reg_addr[3:2];           // addressed channel
  wire logic       wsel2 = reg_wr && (fld == F_SEL2);

  // channel can start: count nonzero and mode single or repeat
  function automatic logic armed(input logic [1:0] m,
                                 input logic [CNT_W-1:0] c);
    armed = (c != CNT_ZERO) &&
            ((m == MODE_SINGLE) || (m == MODE_REPEAT)); // RL11 RL12
  endfunction

  // unit size in bytes for pointer stepping
  function automatic logic [AW-1:0] step(input logic [1:0] sz);
    step = (sz == SZ_32) ? 32'h0000_0004 :
           (sz == SZ_16) ? 32'h0000_0002 : 32'h0000_0001;
  endfunction

  // keep a pointer inside the 64-mbyte space
  function automatic logic [AW-1:0] fold(input logic [AW-1:0] a);
    fold = (a > LOW_LIMIT && a < HIGH_BASE) ? (a & LOW_LIMIT) : a; // RL4
  endfunction

  logic [NUM_CH-1:0] en_w;                        // channel armed
  logic [NUM_CH*5-1:0] sel_w;                     // packed selects
  logic [NUM_CH*5-1:0] sel2_w;                    // packed ext selects
  logic [NUM_CH-1:0] sw_w;                        // sw request writes
  for (genvar c = 0; c < NUM_CH; c++) begin : g_pack
    assign en_w[c]         = armed(mode_q[c][1:0], cnt_q[c]);
    assign sel_w[c*5 +: 5]  = sel_q[c];
    assign sel2_w[c*5 +: 5] = sel2_q[c];
    assign sw_w[c] = wsel2 && (rch == 2'(c)) &&
                     reg_wdata[SWREQ_BIT];        // RL17
  end

  dma_req_latch u_req (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .trig     (trig),
    .sel      (sel_w),
    .sel2     (sel2_w),
    .sw_req   (sw_w),
    .enable   (en_w),
    .rq       (rq.arb)
  );

  // fixed priority: lowest index wins
  wire logic       any_p = |rq.pend;
  wire logic [1:0] win   = rq.pend[0] ? 2'd0 :
                           rq.pend[1] ? 2'd1 :
                           rq.pend[2] ? 2'd2 : 2'd3; // RL3
  wire logic       start = (st_q == ST_IDLE) && any_p;
  assign rq.ack = start ? (NUM_CH'(1) << win) : '0;

  // live channel fields
  wire logic [1:0] c_sz   = mode_q[ch_q][SZ_LO +: 2];
  wire logic       c_rep  = mode_q[ch_q][1:0] == MODE_REPEAT;
  wire logic       c_last = cnt_q[ch_q] == CNT_ONE;
  wire logic       fin    = st_q == ST_DONE;

  // engine state machine: idle, read, write, update
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      ch_q <= 2'd0;
    end else begin
      unique case (st_q)
        ST_IDLE: if (start) begin
          st_q <= ST_READ;                        // RL1
          ch_q <= win;
        end
        ST_READ:  st_q <= ST_WRITE;
        ST_WRITE: st_q <= ST_DONE;
        ST_DONE:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // bus signals, registered; dma holds bus ahead of cpu
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_req     <= 1'b0;
      cpu_bus_gnt <= 1'b0;
      mem_addr    <= ZERO_W;
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      mem_size    <= SZ_8;
      mem_wdata   <= ZERO_W;
      data_q      <= ZERO_W;
    end else begin
      bus_req     <= start || (st_q == ST_READ);          // RL2
      cpu_bus_gnt <= cpu_bus_req && !start &&
                     (st_q != ST_READ);                    // RL2
      mem_rd      <= start;
      mem_wr      <= st_q == ST_READ;
      mem_size    <= start ? mode_q[win][SZ_LO +: 2] : mem_size;
      if (start) begin
        mem_addr <= src_q[win];
      end else if (st_q == ST_READ) begin
        mem_addr <= dst_q[ch_q];
      end
      if (st_q == ST_READ) begin
        data_q    <= mem_rdata;
        mem_wdata <= mem_rdata;
      end
    end
  end

  // complete pulse exactly on the one-to-zero step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tc_irq <= '0;
    end else begin
      tc_irq <= (fin && c_last) ? (NUM_CH'(1) << ch_q) : '0; // RL10
    end
  end

  // channel registers: software writes, engine updates after a unit
  for (genvar c = 0; c < NUM_CH; c++) begin : g_regs
    wire logic hit  = reg_wr && (rch == 2'(c));
    wire logic mine = fin && (ch_q == 2'(c));
    wire logic rep  = mine && c_last && c_rep;    // RL9 RL15
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        mode_q[c] <= '0;
        cnt_q[c]  <= CNT_ZERO;
        crl_q[c]  <= CNT_ZERO;
        src_q[c]  <= ZERO_W;
        srl_q[c]  <= ZERO_W;
        dst_q[c]  <= ZERO_W;
        drl_q[c]  <= ZERO_W;
        sel_q[c]  <= SEL_EXT;
        sel2_q[c] <= SEL_EXT;
        done_q[c] <= 1'b0;
      end else begin
        if (hit && fld == F_MODE) mode_q[c] <= reg_wdata[5:0]; // RL13
        if (hit && fld == F_CRELOAD) crl_q[c] <= reg_wdata;
        if (hit && fld == F_SRELOAD) srl_q[c] <= fold(reg_wdata);
        if (hit && fld == F_DRELOAD) drl_q[c] <= fold(reg_wdata);
        if (hit && fld == F_SEL) sel_q[c] <= reg_wdata[4:0] & SEL_MASK;
        if (hit && fld == F_SEL2) sel2_q[c] <= reg_wdata[4:0] & SEL_MASK;
        // engine update beats software write in the same cycle
        if (rep) begin
          cnt_q[c] <= crl_q[c];                   // RL8 RL9
          src_q[c] <= srl_q[c];                   // RL9
          dst_q[c] <= drl_q[c];                   // RL9
        end else if (mine) begin
          cnt_q[c] <= cnt_q[c] - CNT_ONE;         // RL19 RL5
          if (mode_q[c][SINC_BIT])
            src_q[c] <= fold(src_q[c] + step(c_sz)); // RL6 RL19
          if (mode_q[c][DINC_BIT])
            dst_q[c] <= fold(dst_q[c] + step(c_sz)); // RL6 RL19
        end else begin
          if (hit && fld == F_COUNT) cnt_q[c] <= reg_wdata;
          if (hit && fld == F_SRC) src_q[c] <= fold(reg_wdata); // RL4
          if (hit && fld == F_DST) dst_q[c] <= fold(reg_wdata); // RL4
        end
        // single run ends at zero and stays idle
        if (mine && c_last && !c_rep) begin
          done_q[c] <= 1'b1;                      // RL7
        end else if (hit && (fld == F_COUNT || fld == F_MODE)) begin
          done_q[c] <= 1'b0;
        end
      end
    end
  end

  // read mux, one cycle latency
  logic [DW-1:0] rd_w;                            // selected word
  always_comb begin
    rd_w = ZERO_W;
    unique case (fld)
      F_MODE:    rd_w = {26'h0, mode_q[rch]};
      F_COUNT:   rd_w = cnt_q[rch];
      F_CRELOAD: rd_w = crl_q[rch];
      F_SRC:     rd_w = src_q[rch];
      F_SRELOAD: rd_w = srl_q[rch];
      F_DST:     rd_w = dst_q[rch];
      F_DRELOAD: rd_w = drl_q[rch];
      F_SEL:     rd_w = {27'h0, sel_q[rch]};
      F_SEL2:    rd_w = {27'h0, sel2_q[rch]};
      F_STATUS:  rd_w = {29'h0, tc_irq[rch], rq.pend[rch], done_q[rch]};
      default:   rd_w = ZERO_W;                   // unmapped reads zero
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_W;
    end else begin
      reg_rdata <= reg_rd ? rd_w : ZERO_W;
    end
  end
endmodule

// ---- verif/dma_mem_model.sv ----
// Purpose: shared memory answering the dma on the data bus
// Assumes: read data is returned in the cycle that mem_rd is high
// Notes:   idle data is the inverse of the last value, never stale
`timescale 1ns/100ps
module dma_mem_model
  import dma_pkg::*;
(
  input  wire logic          core_clk,  // system clock
  input  wire logic [AW-1:0] mem_addr,  // bus address
  input  wire logic          mem_rd,    // read strobe
  output logic      [DW-1:0] mem_rdata  // read data
);
  logic [DW-1:0] last_q = ZERO_W;       // last value shown on the bus
  // content is a pattern of the address so the bench can predict it
  assign mem_rdata = mem_rd ? {~mem_addr[15:0], mem_addr[15:0]} : ~last_q;
  // idle data keeps toggling so a late sample is never mistaken for good
  always_ff @(posedge core_clk) begin
    last_q <= mem_rdata;
  end
endmodule

// ---- verif/dma_core_props.sv ----
// Purpose: port-level timing checks of the dma engine
// Assumes: memory walk of read, write, release per unit
// Notes:   word copy is only checked for 32-bit units
`timescale 1ns/100ps
module dma_core_props
  import dma_pkg::*;
(
  input wire logic              core_clk,    // system clock
  input wire logic              rst_n,       // async reset, low
  input wire logic              bus_req,     // dma owns bus
  input wire logic              cpu_bus_gnt, // cpu granted
  input wire logic [AW-1:0]     mem_addr,    // memory address
  input wire logic              mem_rd,      // read strobe
  input wire logic              mem_wr,      // write strobe
  input wire logic [1:0]        mem_size,    // unit size
  input wire logic [DW-1:0]     mem_wdata,   // write data
  input wire logic [DW-1:0]     mem_rdata,   // read data
  input wire logic [NUM_CH-1:0] tc_irq       // complete pulses
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // the two bus steps of one unit
  sequence s_fetch;
    mem_rd && bus_req;
  endsequence
  sequence s_unit;
    mem_rd ##1 mem_wr;
  endsequence
  a_cpu_held: assert property (bus_req |-> !cpu_bus_gnt)
    else $error("cpu granted while dma owns the bus");
  a_fetch_store: assert property (s_fetch |=> mem_wr && bus_req)
    else $error("read not followed by write");
  a_unit_release: assert property (s_unit |=> !mem_wr && !bus_req)
    else $error("bus not released after unit");
  a_unit_gap: assert property (mem_rd |=> !mem_rd [*3])
    else $error("units closer than four cycles");
  a_word_copy: assert property (mem_rd ##1 (mem_wr && mem_size == SZ_32)
    |-> mem_wdata == $past(mem_rdata))
    else $error("written word differs from read word");
  a_size_held: assert property (mem_rd |=> mem_size == $past(mem_size))
    else $error("unit size changed inside unit");
  a_addr_window: assert property ((mem_rd || mem_wr) |->
    (mem_addr <= LOW_LIMIT || mem_addr >= HIGH_BASE))
    else $error("address outside transfer space");
  a_tc_timing: assert property ((|tc_irq) |-> $past(mem_wr, 2))
    else $error("complete pulse without a unit");
  a_tc_single: assert property ($onehot0(tc_irq))
    else $error("two channels completed at once");
endmodule
bind dma_core dma_core_props u_dma_core_props (.core_clk(core_clk),
  .rst_n(rst_n), .bus_req(bus_req), .cpu_bus_gnt(cpu_bus_gnt),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .tc_irq(tc_irq));

// ---- verif/four_channel_cycle_steal_dma_bench.sv ----
// Purpose: register-driven tests of the four-channel dma
// Assumes: read data one cycle after reg_rd, memory model as partner
// Notes:   units are counted from the write strobes on the bus
`timescale 1ns/100ps
module four_channel_cycle_steal_dma_bench;
  import dma_pkg::*;
  logic              core_clk, rst_n, reg_wr, reg_rd, cpu_bus_req;
  logic [RA_W-1:0]   reg_addr;               // register address
  logic [DW-1:0]     reg_wdata, reg_rdata;   // register data
  logic [SRC_W-1:0]  trig;                   // hardware triggers
  logic              bus_req, cpu_bus_gnt, mem_rd, mem_wr;
  logic [AW-1:0]     mem_addr;               // memory address
  logic [1:0]        mem_size;               // unit size
  logic [DW-1:0]     mem_wdata, mem_rdata;   // memory data
  logic [NUM_CH-1:0] tc_irq;                 // complete pulses
  logic [DW-1:0]     wa_q[$], wd_q[$];       // seen write addr/data
  int                tc_cnt[NUM_CH];         // pulses per channel
  int                miscompares, checked, cycles;
  dma_core u_dma_core (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig(trig),
    .bus_req(bus_req), .cpu_bus_req(cpu_bus_req),
    .cpu_bus_gnt(cpu_bus_gnt), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .tc_irq(tc_irq));
  dma_mem_model u_dma_mem_model (.core_clk(core_clk),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  // 10 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // bus monitor and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (mem_wr) begin
      wa_q.push_back(mem_addr);
      wd_q.push_back(mem_wdata);
    end
    for (int i = 0; i < NUM_CH; i++) tc_cnt[i] += int'(tc_irq[i]);
    if (cycles == 4000) begin
      miscompares++;
      end_of_test();
    end
  end
  function automatic logic [7:0] ra(input logic [3:0] f,
                                    input logic [1:0] c);
    return {f, c, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] seen, exp, input string w);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s: %h want %h", $time, w, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, w);
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    trig[i] <= 1'b1;
    @(posedge core_clk);
    trig <= 32'h0000_0000;
  endtask
  // wait for n units, or prove none comes
  task automatic units(input int n);
    int t0;
    int k;
    t0 = wa_q.size();
    k = 0;
    if (n == 0) repeat (12) @(posedge core_clk);
    while (wa_q.size() < t0 + n && k < 60) begin
      @(posedge core_clk);
      k++;
    end
    chk(32'(wa_q.size() - t0), 32'(n), "unit count");
    repeat (3) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = ZERO_W;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig = 32'h0000_0000;
    cpu_bus_req = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(ra(F_COUNT, 2'h0), ZERO_W, "count at reset");
    rc(8'hF0, ZERO_W, "unmapped field");
    wr(ra(F_CRELOAD, 2'h0), 32'hFFFF_FFFF);
    rc(ra(F_CRELOAD, 2'h0), 32'hFFFF_FFFF, "count width");
    chk(32'(cpu_bus_gnt), 32'h0000_0001, "cpu granted idle");
    $display("test registers done");
    // single, word, both pointers increment, software trigger
    wr(ra(F_COUNT, 2'h0), 32'h0000_0002);
    wr(ra(F_SRC, 2'h0), 32'h0000_1000);
    wr(ra(F_DST, 2'h0), 32'hFE00_2000);
    wr(ra(F_MODE, 2'h0), 32'h0000_0039);
    wr(ra(F_SEL2, 2'h0), 32'h0000_0020);
    units(1);
    chk(wa_q[$], 32'hFE00_2000, "first dest");
    chk(wd_q[$], 32'hEFFF_1000, "word data");
    chk(32'(tc_cnt[0]), 32'h0000_0000, "early pulse");
    wr(ra(F_SEL2, 2'h0), 32'h0000_0020);
    units(1);
    chk(32'(tc_cnt[0]), 32'h0000_0001, "last pulse");
    rc(ra(F_COUNT, 2'h0), ZERO_W, "count done");
    rc(ra(F_SRC, 2'h0), 32'h0000_1008, "src step 4");
    rc(ra(F_DST, 2'h0), 32'hFE00_2008, "dst step 4");
    wr(ra(F_SEL2, 2'h0), 32'h0000_0020);
    units(0);
    $display("test single done");
    // repeat, halfword, fixed source, hardware trigger via select
    wr(ra(F_COUNT, 2'h1), 32'h0000_0001);
    wr(ra(F_CRELOAD, 2'h1), 32'h0000_0003);
    wr(ra(F_SRC, 2'h1), 32'h0000_0100);
    wr(ra(F_SRELOAD, 2'h1), 32'h0000_3000);
    wr(ra(F_DST, 2'h1), 32'h0000_0200);
    wr(ra(F_DRELOAD, 2'h1), 32'h0000_4000);
    wr(ra(F_SEL, 2'h1), 32'h0000_0005);
    wr(ra(F_MODE, 2'h1), 32'h0000_0027);
    pulse(5);
    units(1);
    chk(wa_q[$], 32'h0000_0200, "repeat dest");
    chk(32'(tc_cnt[1]), 32'h0000_0001, "repeat pulse");
    rc(ra(F_COUNT, 2'h1), 32'h0000_0003, "count reload");
    rc(ra(F_SRC, 2'h1), 32'h0000_3000, "src reload");
    rc(ra(F_DST, 2'h1), 32'h0000_4000, "dst reload");
    pulse(5);
    units(1);
    rc(ra(F_SRC, 2'h1), 32'h0000_3000, "src fixed");
    rc(ra(F_DST, 2'h1), 32'h0000_4002, "dst step 2");
    wr(ra(F_MODE, 2'h1), 32'h0000_0024);
    pulse(5);
    units(0);
    $display("test repeat done");
    // two channels on one trigger, byte units, reloads ignored
    for (int c = 2; c < 4; c++) begin
      wr(ra(F_COUNT, 2'(c)), 32'h0000_0001);
      wr(ra(F_CRELOAD, 2'(c)), 32'h0000_0005);
      wr(ra(F_SRC, 2'(c)), 32'h0000_5000 + 32'(c - 2) * 32'h0000_0800);
      wr(ra(F_SRELOAD, 2'(c)), 32'h0000_7000);
      wr(ra(F_DST, 2'(c)), 32'h0000_6000 + 32'(c - 2) * 32'h0000_0800);
      wr(ra(F_SEL, 2'(c)), 32'h0000_0007);
      wr(ra(F_MODE, 2'(c)), 32'h0000_0011);
    end
    pulse(7);
    units(2);
    chk(wa_q[$-1], 32'h0000_6000, "lower channel first");
    chk(wa_q[$], 32'h0000_6800, "higher channel next");
    rc(ra(F_SRC, 2'h2), 32'h0000_5001, "src step 1");
    rc(ra(F_COUNT, 2'h3), ZERO_W, "no count reload");
    $display("test priority done");
    end_of_test();
  end
endmodule
